// ---- cbs_top.sv ----
// channel blocking registers and the two per-timeslot strobe outputs
`timescale 1ns/1ps
`default_nettype none

`include "cbs_defines.svh"

// Functional notes
// - rx strobe from rx bits, tx from tx
// - bit set holds strobe high whole slot
// - bit clear keeps strobe low whole slot
// - t1 mode ignores channels 25 to 32
// - rx bits at 88h-8Bh, channel 1 lowest
// - tx bits at 8Ch-8Fh, channel 1 lowest
module cbs_top #(
  parameter int NUM_CH = `CBS_E1_CHANNELS,
  parameter int T1_CH  = `CBS_T1_CHANNELS
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       t1_mode,
  input  wire logic       rx_slot_tick,
  input  wire logic       rx_frame_start,
  input  wire logic       tx_slot_tick,
  input  wire logic       tx_frame_start,
  output logic            rx_slot_strobe,
  output logic            tx_slot_strobe
);

  cbs_pkg::cbs_top_s s_q;
  cbs_pkg::cbs_top_s s_d;

  cbs_dir_if rx_if ();
  cbs_dir_if tx_if ();

  // true when addr falls in the four bytes starting at base
  function automatic logic in_bank(input logic [7:0] addr,
                                   input logic [7:0] base);
    in_bank = (addr >= base) && (addr <= base + 8'h03);
  endfunction : in_bank

  // byte lane within a bank: lane 0 holds channels 1..8
  function automatic logic [1:0] lane_of(input logic [7:0] addr,
                                         input logic [7:0] base);
    logic [7:0] diff;
    diff    = addr - base;
    lane_of = diff[1:0];
  endfunction : lane_of

  // replace one byte lane of a 32-channel bit vector
  function automatic logic [31:0] put_byte(input logic [31:0] bits,
                                           input logic [1:0]  lane,
                                           input logic [7:0]  data);
    logic [31:0] r;
    r = bits;
    r[8*lane +: 8] = data;
    put_byte = r;
  endfunction : put_byte

  // full read decode; unmapped addresses read as zero
  function automatic logic [7:0] read_reg(input logic [7:0]  addr,
                                          input logic [31:0] rxb,
                                          input logic [31:0] txb,
                                          input logic [7:0]  sts);
    if (in_bank(addr, `CBS_RX_BLOCK_CH1_8_OFF)) begin
      read_reg = rxb[8*lane_of(addr, `CBS_RX_BLOCK_CH1_8_OFF) +: 8];
    end else if (in_bank(addr, `CBS_TX_BLOCK_CH1_8_OFF)) begin
      read_reg = txb[8*lane_of(addr, `CBS_TX_BLOCK_CH1_8_OFF) +: 8];
    end else if (addr == `CBS_STATUS_OFF) begin
      read_reg = sts;
    end else begin
      read_reg = `CBS_READ_IDLE;
    end
  endfunction : read_reg

  logic [7:0] status;

  // live view of both generators; handy for checking frame alignment
  always_comb begin
    status = 8'h00;
    status[`CBS_STS_RX_STROBE_BIT] = rx_if.strobe;
    status[`CBS_STS_TX_STROBE_BIT] = tx_if.strobe;
    status[`CBS_STS_RX_FRAMED_BIT] = rx_if.in_frame;
    status[`CBS_STS_TX_FRAMED_BIT] = tx_if.in_frame;
    status[`CBS_STS_T1_MODE_BIT]   = t1_mode;
  end

  // register writes and reads; a write and read in one cycle returns old data
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    if (reg_wr) begin
      if (in_bank(reg_addr, `CBS_RX_BLOCK_CH1_8_OFF)) begin
        s_d.rx_bits = put_byte(s_q.rx_bits,
                               lane_of(reg_addr, `CBS_RX_BLOCK_CH1_8_OFF),
                               reg_wdata);
      end else if (in_bank(reg_addr, `CBS_TX_BLOCK_CH1_8_OFF)) begin
        s_d.tx_bits = put_byte(s_q.tx_bits,
                               lane_of(reg_addr, `CBS_TX_BLOCK_CH1_8_OFF),
                               reg_wdata);
      end
    end
    if (reg_rd) begin
      s_d.rdata  = read_reg(reg_addr, s_q.rx_bits, s_q.tx_bits, status);
      s_d.rvalid = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.rx_bits <= `CBS_BLOCK_WORD_RST;
      s_q.tx_bits <= `CBS_BLOCK_WORD_RST;
      s_q.rdata   <= `CBS_READ_IDLE;
      s_q.rvalid  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // each direction sees only its own bit set and its own framer timing
  assign rx_if.block_bits = s_q.rx_bits;
  assign tx_if.block_bits = s_q.tx_bits;
  assign rx_if.t1_mode    = t1_mode;
  assign tx_if.t1_mode    = t1_mode;

  cbs_slot_strobe #(
    .NUM_CH (NUM_CH),
    .T1_CH  (T1_CH)
  ) u_rx_gen (
    .clock       (clock),
    .rst         (rst),
    .slot_tick   (rx_slot_tick),
    .frame_start (rx_frame_start),
    .dir         (rx_if.gen)
  );

  cbs_slot_strobe #(
    .NUM_CH (NUM_CH),
    .T1_CH  (T1_CH)
  ) u_tx_gen (
    .clock       (clock),
    .rst         (rst),
    .slot_tick   (tx_slot_tick),
    .frame_start (tx_frame_start),
    .dir         (tx_if.gen)
  );

  assign rx_slot_strobe = rx_if.strobe;
  assign tx_slot_strobe = tx_if.strobe;
  assign reg_rdata      = s_q.rdata;
  assign reg_rvalid     = s_q.rvalid;

endmodule : cbs_top

`default_nettype wire

// ---- cbs_defines.svh ----
// register offsets, reset values and channel counts for the channel strobes
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH

`define CBS_RX_BLOCK_CH1_8_OFF   8'h88
`define CBS_RX_BLOCK_CH9_16_OFF  8'h89
`define CBS_RX_BLOCK_CH17_24_OFF 8'h8A
`define CBS_RX_BLOCK_CH25_32_OFF 8'h8B
`define CBS_TX_BLOCK_CH1_8_OFF   8'h8C
`define CBS_TX_BLOCK_CH9_16_OFF  8'h8D
`define CBS_TX_BLOCK_CH17_24_OFF 8'h8E
`define CBS_TX_BLOCK_CH25_32_OFF 8'h8F
`define CBS_STATUS_OFF           8'h9F

`define CBS_BLOCK_BYTE_RST       8'h00
`define CBS_BLOCK_WORD_RST       32'h0000_0000
`define CBS_READ_IDLE            8'h00

`define CBS_STS_RX_STROBE_BIT    0
`define CBS_STS_TX_STROBE_BIT    1
`define CBS_STS_RX_FRAMED_BIT    2
`define CBS_STS_TX_FRAMED_BIT    3
`define CBS_STS_T1_MODE_BIT      4

`define CBS_E1_CHANNELS          32
`define CBS_T1_CHANNELS          24

`endif

// ---- cbs_pkg.sv ----
// types shared by the channel strobe modules
`default_nettype none

package cbs_pkg;

  typedef logic [4:0] cbs_slot_t;

  // register side state of the top module
  typedef struct packed {
    logic [31:0] rx_bits;
    logic [31:0] tx_bits;
    logic [7:0]  rdata;
    logic        rvalid;
  } cbs_top_s;

  // per-direction timeslot tracker state
  typedef struct packed {
    cbs_slot_t slot;
    logic      in_frame;
    logic      strobe;
  } cbs_gen_s;

endpackage : cbs_pkg

`default_nettype wire

// ---- cbs_dir_if.sv ----
// link between the register file and one direction's strobe generator
`timescale 1ns/1ps
`default_nettype none

interface cbs_dir_if;
  logic [31:0]       block_bits;
  logic              t1_mode;
  cbs_pkg::cbs_slot_t slot;
  logic              in_frame;
  logic              strobe;

  modport ctl (output block_bits, output t1_mode,
               input slot, input in_frame, input strobe);
  modport gen (input block_bits, input t1_mode,
               output slot, output in_frame, output strobe);
endinterface : cbs_dir_if

`default_nettype wire

// ---- cbs_slot_strobe.sv ----
// one direction's timeslot tracker and strobe generator
`timescale 1ns/1ps
`default_nettype none

`include "cbs_defines.svh"

module cbs_slot_strobe #(
  parameter int NUM_CH = `CBS_E1_CHANNELS,
  parameter int T1_CH  = `CBS_T1_CHANNELS
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic slot_tick,
  input  wire logic frame_start,
  cbs_dir_if.gen    dir
);

  localparam cbs_pkg::cbs_slot_t LAST_SLOT = cbs_pkg::cbs_slot_t'(NUM_CH - 1);
  // one bit wider than a slot so a t1 count of 32 does not wrap to zero
  localparam logic [5:0]         T1_LIMIT  = 6'(T1_CH);

  // the 5-bit slot counter covers 32 slots and the bit vector is 32 wide; anything else cannot map
  if (NUM_CH < 1 || NUM_CH > 32 || T1_CH < 1 || T1_CH > NUM_CH) begin : g_bad
    $error("cbs_slot_strobe: channel counts out of range");
  end

  cbs_pkg::cbs_gen_s g_q;
  cbs_pkg::cbs_gen_s g_d;

  // a channel above the t1 count never raises the strobe in t1 mode
  function automatic logic chan_live(input cbs_pkg::cbs_slot_t s,
                                     input logic t1);
    chan_live = !(t1 && ({1'b0, s} >= T1_LIMIT));
  endfunction : chan_live

  // level changes only on a slot tick, sampling the bits current right then
  always_comb begin
    g_d = g_q;
    if (slot_tick) begin
      if (frame_start) begin
        g_d.slot     = '0;
        g_d.in_frame = 1'b1;
      end else if (g_q.slot == LAST_SLOT) begin
        // ticks past the last channel without a frame mark: stay low
        g_d.in_frame = 1'b0;
      end else begin
        g_d.slot = g_q.slot + 5'h1;
      end
      // bit set: high for the slot; bit clear: low for the slot
      g_d.strobe = g_d.in_frame && chan_live(g_d.slot, dir.t1_mode) &&
                   dir.block_bits[g_d.slot];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      g_q <= '0;
    end else begin
      g_q <= g_d;
    end
  end

  assign dir.slot     = g_q.slot;
  assign dir.in_frame = g_q.in_frame;
  assign dir.strobe   = g_q.strobe;

endmodule : cbs_slot_strobe

`default_nettype wire

// ---- cbs_checker.sv ----
// assertions on the channel strobe top ports
`timescale 1ns/1ps
`default_nettype none
`include "cbs_defines.svh"
module cbs_checker #(
  parameter int NUM_CH = 32,
  parameter int T1_CH  = 24
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       t1_mode,
  input wire logic       rx_slot_tick,
  input wire logic       rx_frame_start,
  input wire logic       tx_slot_tick,
  input wire logic       tx_frame_start,
  input wire logic       rx_slot_strobe,
  input wire logic       tx_slot_strobe
);
  logic [31:0]      bits_q [2];
  logic [4:0]       slot_q [2];
  logic [1:0]       inf_q;
  logic [1:0]       exp_q;
  logic [7:0]       rexp_q;
  wire  logic [1:0] tk  = {tx_slot_tick, rx_slot_tick};
  wire  logic [1:0] fs  = {tx_frame_start, rx_frame_start};
  wire  logic       hit = reg_addr[7:3] == 5'h11;
  // shadow bits and slot position; bits sampled before a same-edge write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bits_q <= '{2{32'h0000_0000}};
      slot_q <= '{2{5'h00}};
      inf_q  <= 2'h0;
      exp_q  <= 2'h0;
      rexp_q <= 8'h00;
    end else begin
      if (reg_rd)
        rexp_q <= bits_q[reg_addr[2]][{reg_addr[1:0], 3'h0} +: 8];
      if (reg_wr && hit)
        bits_q[reg_addr[2]][{reg_addr[1:0], 3'h0} +: 8] <= reg_wdata;
      for (int d = 0; d < 2; d++) begin
        if (tk[d]) begin
          slot_q[d] <= fs[d] ? 5'h00 : slot_q[d] + 5'h01;
          inf_q[d]  <= fs[d] | (inf_q[d] & (slot_q[d] != 5'(NUM_CH - 1)));
          exp_q[d]  <= fs[d] ? bits_q[d][0] : inf_q[d]
                       && slot_q[d] != 5'(NUM_CH - 1)
                       && !(t1_mode && slot_q[d] >= 5'(T1_CH - 1))
                       && bits_q[d][slot_q[d] + 5'h01];
        end
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rd_map; reg_rd && hit; endsequence
  sequence s_answer; reg_rvalid && reg_rdata == rexp_q; endsequence
  a_rx_strobe_bit: assert property (rx_slot_strobe == exp_q[0])
    else $error("rx strobe differs from its bit");
  a_tx_strobe_bit: assert property (tx_slot_strobe == exp_q[1])
    else $error("tx strobe differs from its bit");
  a_rx_slot_hold: assert property (!rx_slot_tick |=> $stable(rx_slot_strobe))
    else $error("rx strobe moved inside a slot");
  a_tx_slot_hold: assert property (!tx_slot_tick |=> $stable(tx_slot_strobe))
    else $error("tx strobe moved inside a slot");
  a_t1_rx_mask: assert property (rx_slot_tick && !rx_frame_start && t1_mode
    && slot_q[0] >= 5'(T1_CH - 1) |=> !rx_slot_strobe)
    else $error("rx strobe high past channel 24");
  a_t1_tx_mask: assert property (tx_slot_tick && !tx_frame_start && t1_mode
    && slot_q[1] >= 5'(T1_CH - 1) |=> !tx_slot_strobe)
    else $error("tx strobe high past channel 24");
  a_read_answer: assert property (s_rd_map |=> s_answer)
    else $error("read answer wrong");
  a_valid_pulse: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without request");
endmodule : cbs_checker
`default_nettype wire

// ---- cbs_framer_model.sv ----
// framer timing source: slot ticks and frame starts
`timescale 1ns/1ps
`default_nettype none
module cbs_framer_model #(
  parameter int GAP = 3
) (
  input  wire logic clock,
  input  wire logic rst,
  output logic      tick,
  output logic      fstart
);
  int cnt;
  int slot;
  // a tick every GAP cycles; frame start rides the tick of channel 1
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt    <= 0;
      slot   <= 0;
      tick   <= 1'b0;
      fstart <= 1'b0;
    end else begin
      cnt    <= (cnt == GAP - 1) ? 0 : cnt + 1;
      tick   <= cnt == 0;
      fstart <= cnt == 0 && slot == 0;
      if (cnt == 0)
        slot <= (slot == 31) ? 0 : slot + 1;
    end
  end
endmodule : cbs_framer_model
`default_nettype wire

// ---- channel_blocking_strobes_tb.sv ----
// self-checking bench for the channel blocking strobes
`timescale 1ns/1ps
`default_nettype none
module channel_blocking_strobes_tb;
  localparam logic [63:0] PAT = 64'h5A3C_F07E_A5C3_0F81;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       t1_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  wire  logic [1:0] tk, fs, stb;
  int         num_errors = 0;
  int         checks = 0;
  always #10 clock = ~clock;
  // rx and tx framers tick at unrelated rates to keep directions apart
  cbs_framer_model #(.GAP(3)) rx_fr_inst (.clock(clock), .rst(rst),
    .tick(tk[0]), .fstart(fs[0]));
  cbs_framer_model #(.GAP(5)) tx_fr_inst (.clock(clock), .rst(rst),
    .tick(tk[1]), .fstart(fs[1]));
  cbs_top cbs_top_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .t1_mode(t1_mode),
    .rx_slot_tick(tk[0]), .rx_frame_start(fs[0]), .tx_slot_tick(tk[1]),
    .tx_frame_start(fs[1]), .rx_slot_strobe(stb[0]),
    .tx_slot_strobe(stb[1]));
  task automatic conclude();
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, e);
  endtask : rd
  // follow one frame of direction d; strobe settles just after each tick
  task automatic frame(input int d, input logic [31:0] b);
    int n;
    int s;
    n = 0;
    s = -1;
    while (n < 600 && s < 31) begin
      @(negedge clock);
      n++;
      if (tk[d] === 1'b1 && (s >= 0 || fs[d] === 1'b1)) begin
        s = (fs[d] === 1'b1) ? 0 : s + 1;
        @(posedge clock);
        #1;
        chk({7'h00, stb[d]}, {7'h00, b[s] & !(t1_mode && s >= 24)});
      end
    end
    if (s < 31) begin
      num_errors++;
      $display("wrong value at %0t: no full frame seen", $time);
      conclude();
    end
  endtask : frame
  task automatic regs_reset();
    for (int i = 0; i < 8; i++)
      rd(8'h88 + 8'(i), 8'h00);
    rd(8'h20, 8'h00);
  endtask : regs_reset
  task automatic regs_map();
    for (int i = 0; i < 8; i++)
      wr(8'h88 + 8'(i), PAT[8*i +: 8]);
    // writes just outside both banks must leave them untouched
    wr(8'h87, 8'hFF);
    wr(8'h90, 8'hFF);
    rd(8'h87, 8'h00);
    for (int i = 0; i < 8; i++)
      rd(8'h88 + 8'(i), PAT[8*i +: 8]);
  endtask : regs_map
  task automatic e1_frames();
    frame(0, PAT[31:0]);
    frame(1, PAT[63:32]);
  endtask : e1_frames
  task automatic t1_frames();
    @(posedge clock);
    t1_mode <= 1'b1;
    frame(0, PAT[31:0]);
    frame(1, PAT[63:32]);
  endtask : t1_frames
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    regs_reset();
    regs_map();
    e1_frames();
    t1_frames();
    conclude();
  end
endmodule : channel_blocking_strobes_tb
bind cbs_top cbs_checker #(.NUM_CH(NUM_CH), .T1_CH(T1_CH)) cbs_checker_inst (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .t1_mode(t1_mode), .rx_slot_tick(rx_slot_tick),
  .rx_frame_start(rx_frame_start), .tx_slot_tick(tx_slot_tick),
  .tx_frame_start(tx_frame_start), .rx_slot_strobe(rx_slot_strobe),
  .tx_slot_strobe(tx_slot_strobe));
`default_nettype wire
